//--- hdl/pds_device.sv
// What this block does
// [R1] Shift 19 bits, one per serial rising edge, MSB first
// [R2] Control high loads reference ratio and modulus bit
// [R3] Control low loads swallow and programmable counters
// [R4] Reference divider ratio 3 to 16383, binary
// [R5] Modulus bit zero 128/129, one 64/65
// [R6] Swallow count from low seven bits, 0-127
// [R7] Programmable ratio from upper eleven bits, 3-2047
// [R8] Host keeps swallow count not above ratio
// [R9] Feedback total is modulus times ratio plus swallow
// [R10] Polarity pin inverts phase detector, all pump outputs
// [R11] Monitor shows reference clock high, feedback clock low
// [R12] System sets polarity pin to match VCO slope
// [R13] Comparator resolves errors from minus to plus two pi
// [R14] Locked comparator still emits minimum-width up and down
// [R15] Strobe high also routes pump to scan switch
// [R16] Host respects strobe setup time and pulse width
// [R17] Larger modulus until swallow exhausted, then smaller
// [R18] Latches load on strobe after nineteenth edge only
module pds_device
    import pds_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Programming link
    pds_link_if.device link,
    // Analog-side inputs, sampled
    input wire logic reference_osc_input,
    input wire logic vco_sense_input,
    input wire logic polarity_select_pin,
    // Charge pump and monitor outputs
    output logic pump_output,
    output logic pump_output_oe,
    output logic scan_switch_output,
    output logic scan_switch_oe,
    output logic pump_up_ext,
    output logic pump_down_ext,
    output logic compare_monitor_pin,
    // Latched divider settings
    output logic [REF_W-1:0] ref_ratio,
    output logic prescale_modulus_bit,
    output logic [SWALLOW_W-1:0] swallow_count,
    output logic [PROG_W-1:0] prog_ratio
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    localparam int N_IN = 6;
    localparam int I_SCLK = 0;
    localparam int I_SDATA = 1;
    localparam int I_STRB = 2;
    localparam int I_REF = 3;
    localparam int I_VCO = 4;
    localparam int I_POL = 5;

    logic [N_IN-1:0] sync1_r;
    logic [N_IN-1:0] sync2_r;
    logic [N_IN-1:0] sync3_r;
    logic [N_IN-1:0] stable_r;
    logic [N_IN-1:0] stable_d_r;
    logic [N_IN-1:0] agree;
    logic [N_IN-1:0] rise;
    logic [N_IN-1:0] raw_in;

    assign raw_in = {polarity_select_pin, vco_sense_input, reference_osc_input,
                     link.load_strobe, link.serial_data, link.serial_clock};
    assign agree = ~(sync2_r ^ sync3_r);
    assign rise = stable_r & ~stable_d_r;

    // Three-stage chain; a change counts when stages two and three agree
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            sync1_r <= '0;
            sync2_r <= '0;
            sync3_r <= '0;
            stable_r <= '0;
            stable_d_r <= '0;
        end
        else
        begin
            sync1_r <= raw_in;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            stable_r <= (stable_r & ~agree) | (sync3_r & agree);
            stable_d_r <= stable_r;
        end
    end

    // ------------------------------------------------------------
    // Serial shift register and latches
    // ------------------------------------------------------------
    logic [WORD_W-1:0] shift_r;
    logic [4:0] bit_cnt_r;

    // Shift on serial clock rising edge, count edges up to a full word
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            shift_r <= '0;
            bit_cnt_r <= '0;
        end
        else if (rise[I_STRB])
        begin
            bit_cnt_r <= '0;
        end
        else if (rise[I_SCLK])
        begin
            shift_r <= {shift_r[WORD_W-2:0], stable_r[I_SDATA]}; // [R1]
            if (bit_cnt_r != WORD_BITS)
            begin
                bit_cnt_r <= bit_cnt_r + 5'h01;
            end
        end
    end

    // Transfer to the latch group picked by the control bit
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ref_ratio <= REF_RATIO_RST;
            prescale_modulus_bit <= MOD_BIT_RST;
            swallow_count <= SWALLOW_RST;
            prog_ratio <= PROG_RATIO_RST;
        end
        else if (rise[I_STRB] && bit_cnt_r == WORD_BITS) // [R18]
        begin
            if (shift_r[CTRL_POS])
            begin
                ref_ratio <= shift_r[REF_LSB +: REF_W]; // [R2] [R4]
                prescale_modulus_bit <= shift_r[MOD_POS]; // [R2] [R5]
            end
            else
            begin
                swallow_count <= shift_r[SWALLOW_LSB +: SWALLOW_W]; // [R3] [R6]
                prog_ratio <= shift_r[PROG_LSB +: PROG_W]; // [R3] [R7]
            end
        end
    end

    // ------------------------------------------------------------
    // Reference divider
    // ------------------------------------------------------------
    logic [REF_W-1:0] ref_cnt_r;
    logic ref_pulse_r;

    // One pulse per ref_ratio oscillator edges
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ref_cnt_r <= '0;
            ref_pulse_r <= 1'b0;
        end
        else
        begin
            ref_pulse_r <= 1'b0;
            if (rise[I_REF])
            begin
                if (ref_cnt_r >= ref_ratio - 14'h0001) // [R4]
                begin
                    ref_cnt_r <= '0;
                    ref_pulse_r <= 1'b1;
                end
                else
                begin
                    ref_cnt_r <= ref_cnt_r + 14'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Dual-modulus prescaler and pulse-swallow counters
    // ------------------------------------------------------------
    logic [7:0] pre_cnt_r;
    logic [7:0] modulus;
    logic [SWALLOW_W-1:0] swallow_left_r;
    logic [PROG_W-1:0] prog_cnt_r;
    logic loop_pulse_r;

    // Larger modulus while swallows remain
    always_comb
    begin
        modulus = prescale_modulus_bit ? MODULUS_SMALL : MODULUS_LARGE; // [R5]
        if (swallow_left_r != '0)
        begin
            modulus = modulus + 8'h01; // [R17]
        end
    end

    // Total per loop pulse: modulus*prog_ratio + swallow_count
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pre_cnt_r <= '0;
            swallow_left_r <= SWALLOW_RST;
            prog_cnt_r <= '0;
            loop_pulse_r <= 1'b0;
        end
        else
        begin
            loop_pulse_r <= 1'b0;
            if (rise[I_VCO])
            begin
                if (pre_cnt_r >= modulus - 8'h01)
                begin
                    pre_cnt_r <= '0;
                    if (prog_cnt_r >= prog_ratio - 11'h001) // [R9]
                    begin
                        prog_cnt_r <= '0;
                        swallow_left_r <= swallow_count; // [R6]
                        loop_pulse_r <= 1'b1;
                    end
                    else
                    begin
                        prog_cnt_r <= prog_cnt_r + 11'h001;
                        if (swallow_left_r != '0)
                        begin
                            swallow_left_r <= swallow_left_r - 7'h01; // [R17]
                        end
                    end
                end
                else
                begin
                    pre_cnt_r <= pre_cnt_r + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Phase-frequency detector
    // ------------------------------------------------------------
    logic ref_lead_r;
    logic loop_lead_r;
    logic both_set;

    assign both_set = ref_lead_r & loop_lead_r;

    // Each edge sets its flag; both set clears both, a new edge wins
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            ref_lead_r <= 1'b0;
            loop_lead_r <= 1'b0;
        end
        else
        begin
            ref_lead_r <= ref_pulse_r | (ref_lead_r & ~both_set); // [R13] [R14]
            loop_lead_r <= loop_pulse_r | (loop_lead_r & ~both_set); // [R13] [R14]
        end
    end

    // ------------------------------------------------------------
    // Pump, scan switch and monitor outputs
    // ------------------------------------------------------------
    logic pol;
    logic up_w;
    logic down_w;

    assign pol = stable_r[I_POL];
    assign up_w = pol ? ref_lead_r : loop_lead_r; // [R10]
    assign down_w = pol ? loop_lead_r : ref_lead_r; // [R10]

    // Registered pins; pump drives high on up alone, low on down (also when up and down are both set)
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            pump_up_ext <= 1'b0;
            pump_down_ext <= 1'b0;
            pump_output <= 1'b0;
            pump_output_oe <= 1'b0;
            scan_switch_output <= 1'b0;
            scan_switch_oe <= 1'b0;
            compare_monitor_pin <= 1'b0;
        end
        else
        begin
            pump_up_ext <= up_w; // [R10]
            pump_down_ext <= down_w; // [R10]
            pump_output <= up_w & ~down_w;
            pump_output_oe <= up_w | down_w; // [R14]
            scan_switch_output <= up_w & ~down_w;
            scan_switch_oe <= (up_w | down_w) & stable_r[I_STRB]; // [R15]
            compare_monitor_pin <= pol ? ref_pulse_r : loop_pulse_r; // [R11]
        end
    end

endmodule

//--- hdl/pds_pkg.sv
package pds_pkg;

    // ------------------------------------------------------------
    // Serial word layout
    // ------------------------------------------------------------
    localparam int WORD_W = 19;
    localparam int REF_W = 14;
    localparam int SWALLOW_W = 7;
    localparam int PROG_W = 11;
    localparam int CTRL_POS = 0;
    localparam int REF_LSB = 1;
    localparam int MOD_POS = 15;
    localparam int SWALLOW_LSB = 1;
    localparam int PROG_LSB = 8;
    localparam logic [4:0] WORD_BITS = 5'h13;

    // ------------------------------------------------------------
    // Divider limits and values after reset
    // ------------------------------------------------------------
    localparam logic [REF_W-1:0] REF_RATIO_MIN = 14'h0003;
    localparam logic [PROG_W-1:0] PROG_RATIO_MIN = 11'h003;
    localparam logic [REF_W-1:0] REF_RATIO_RST = 14'h0003;
    localparam logic [PROG_W-1:0] PROG_RATIO_RST = 11'h003;
    localparam logic [SWALLOW_W-1:0] SWALLOW_RST = 7'h00;
    localparam logic MOD_BIT_RST = 1'b0;
    localparam logic [7:0] MODULUS_LARGE = 8'h80;
    localparam logic [7:0] MODULUS_SMALL = 8'h40;

    // ------------------------------------------------------------
    // Link timing at 20 MHz
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 50;
    localparam int T_LINK_MIN_NS = 50;
    localparam int LINK_MIN_CYC = (T_LINK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HALF_BIT_CYC_DEF = 4;

    // Host sequencer states
    typedef enum logic [2:0]
    {
        HS_IDLE = 3'b000,
        HS_LOW = 3'b001,
        HS_HIGH = 3'b011,
        HS_SETUP = 3'b010,
        HS_STROBE = 3'b110
    } pds_host_state_t;

endpackage

//--- hdl/pds_link_if.sv
interface pds_link_if;

    // Three-wire programming link
    logic serial_clock;
    logic serial_data;
    logic load_strobe;

    modport host
    (
        output serial_clock,
        output serial_data,
        output load_strobe
    );

    modport device
    (
        input serial_clock,
        input serial_data,
        input load_strobe
    );

endinterface

//--- hdl/pds_host.sv
module pds_host
    import pds_pkg::*;
#(
    parameter int HALF_BIT_CYC = HALF_BIT_CYC_DEF
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Word request
    input wire logic cmd_valid,
    input wire logic [WORD_W-1:0] cmd_word,
    output logic cmd_ready,
    output logic cmd_error,
    output logic cmd_done,
    // Programming link
    pds_link_if.host link
);

    // ------------------------------------------------------------
    // Word checks and half-bit divider
    // ------------------------------------------------------------
    localparam int HALF_CYC = (HALF_BIT_CYC > LINK_MIN_CYC) ? HALF_BIT_CYC : LINK_MIN_CYC;
    localparam logic [7:0] HALF_LAST = 8'(HALF_CYC - 1);

    // Refuse words that break the ratio limits
    function automatic logic word_bad(input logic [WORD_W-1:0] w);
        if (w[CTRL_POS])
        begin
            return w[REF_LSB +: REF_W] < REF_RATIO_MIN; // [R4]
        end
        return (w[PROG_LSB +: PROG_W] < PROG_RATIO_MIN) // [R7]
            || ({4'h0, w[SWALLOW_LSB +: SWALLOW_W]} > w[PROG_LSB +: PROG_W]); // [R8]
    endfunction

    pds_host_state_t state_r;
    logic [7:0] div_r;
    logic tick;
    logic [WORD_W-1:0] word_r;
    logic [4:0] bits_left_r;

    assign tick = (div_r == HALF_LAST);

    // Half-bit enable, restarted on every state change
    always_ff @(posedge clk_sys)
    begin
        if (rst || state_r == HS_IDLE || tick)
        begin
            div_r <= '0;
        end
        else
        begin
            div_r <= div_r + 8'h01;
        end
    end

    // ------------------------------------------------------------
    // Link sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            state_r <= HS_IDLE;
            word_r <= '0;
            bits_left_r <= '0;
            link.serial_clock <= 1'b0;
            link.serial_data <= 1'b0;
            link.load_strobe <= 1'b0;
            cmd_ready <= 1'b0;
            cmd_error <= 1'b0;
            cmd_done <= 1'b0;
        end
        else
        begin
            cmd_error <= 1'b0;
            cmd_done <= 1'b0;
            unique case (state_r)
                HS_IDLE:
                begin
                    cmd_ready <= 1'b1;
                    if (cmd_valid && cmd_ready)
                    begin
                        cmd_ready <= 1'b0;
                        if (word_bad(cmd_word))
                        begin
                            cmd_error <= 1'b1;
                        end
                        else
                        begin
                            word_r <= {cmd_word[WORD_W-2:0], 1'b0};
                            link.serial_data <= cmd_word[WORD_W-1]; // [R1]
                            bits_left_r <= WORD_BITS;
                            state_r <= HS_LOW;
                        end
                    end
                end
                HS_LOW:
                begin
                    if (tick)
                    begin
                        link.serial_clock <= 1'b1;
                        bits_left_r <= bits_left_r - 5'h01;
                        state_r <= HS_HIGH;
                    end
                end
                HS_HIGH:
                begin
                    if (tick)
                    begin
                        link.serial_clock <= 1'b0;
                        if (bits_left_r == '0)
                        begin
                            state_r <= HS_SETUP;
                        end
                        else
                        begin
                            link.serial_data <= word_r[WORD_W-1]; // [R1]
                            word_r <= {word_r[WORD_W-2:0], 1'b0};
                            state_r <= HS_LOW;
                        end
                    end
                end
                HS_SETUP:
                begin
                    if (tick)
                    begin
                        link.load_strobe <= 1'b1; // [R16]
                        state_r <= HS_STROBE;
                    end
                end
                HS_STROBE:
                begin
                    if (tick)
                    begin
                        link.load_strobe <= 1'b0; // [R16]
                        cmd_done <= 1'b1;
                        state_r <= HS_IDLE;
                    end
                end
            endcase
        end
    end

endmodule

//--- bench/pds_link_props.sv
module pds_link_props
#(
    parameter int H = 4
)
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // Three-wire link
    input wire logic serial_clock,
    input wire logic serial_data,
    input wire logic load_strobe
);

    timeunit 1ns;
    timeprecision 1ps;

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (rst);

    // ----------
    // Run counters
    // ----------
    logic [7:0] hi_cnt_r;
    logic [7:0] lo_cnt_r;
    logic [7:0] st_cnt_r;
    logic [7:0] edge_cnt_r;
    logic sclk_q_r;

    // Cycles the serial clock has spent high or low
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            hi_cnt_r <= 8'h00;
            lo_cnt_r <= 8'h00;
        end
        else
        begin
            hi_cnt_r <= serial_clock ? hi_cnt_r + 8'h01 : 8'h00;
            lo_cnt_r <= serial_clock ? 8'h00 : (lo_cnt_r == 8'hff ? lo_cnt_r : lo_cnt_r + 8'h01);
        end
    end

    // Strobe length and clock rises since the last strobe
    always_ff @(posedge clk_sys)
    begin
        if (rst)
        begin
            st_cnt_r <= 8'h00;
            edge_cnt_r <= 8'h00;
            sclk_q_r <= 1'b0;
        end
        else
        begin
            st_cnt_r <= load_strobe ? st_cnt_r + 8'h01 : 8'h00;
            sclk_q_r <= serial_clock;
            if (load_strobe)
                edge_cnt_r <= 8'h00;
            else if (serial_clock && !sclk_q_r)
                edge_cnt_r <= edge_cnt_r + 8'h01;
        end
    end

    // ----------
    // Link properties
    // ----------
    sequence s_link_quiet;
        (!serial_clock && !load_strobe) [*3];
    endsequence

    sequence s_strobe_end;
        $fell(load_strobe) ##0 (st_cnt_r == 8'(H));
    endsequence

    data_hold_high_a: assert property (serial_clock |-> $stable(serial_data))
        else $error("serial data moved while serial clock high");
    strobe_clk_low_a: assert property (load_strobe |-> !serial_clock)
        else $error("serial clock high during strobe");
    clk_high_len_a: assert property ($fell(serial_clock) |-> hi_cnt_r == 8'(H))
        else $error("serial clock high phase has wrong length");
    clk_low_len_a: assert property ($rose(serial_clock) |-> lo_cnt_r >= 8'(H))
        else $error("serial clock low phase too short");
    strobe_setup_a: assert property ($rose(load_strobe) |-> lo_cnt_r >= 8'(H))
        else $error("strobe raised too soon after last clock");
    strobe_width_a: assert property ($fell(load_strobe) |-> s_strobe_end)
        else $error("strobe pulse has wrong width");
    word_bits_a: assert property ($rose(load_strobe) |-> edge_cnt_r == 8'h13)
        else $error("strobe not preceded by nineteen clock rises");
    strobe_gap_a: assert property ($fell(load_strobe) |-> s_link_quiet)
        else $error("link active right after strobe");

endmodule

//--- bench/tb_top.sv
module tb_top
    import pds_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int HALF = 4;
    localparam int OSC_HALF = 5;
    localparam int VCO_HALF = 6;
    localparam int LIMIT = 60000;

    // ----------
    // Signals and bench state
    // ----------
    logic clk_sys, rst, cmd_valid, cmd_ready, cmd_error, cmd_done;
    logic [WORD_W-1:0] cmd_word;
    logic reference_osc_input, vco_sense_input, polarity_select_pin;
    logic pump_output, pump_output_oe, scan_switch_output, scan_switch_oe;
    logic pump_up_ext, pump_down_ext, compare_monitor_pin, prescale_modulus_bit;
    logic [REF_W-1:0] ref_ratio;
    logic [SWALLOW_W-1:0] swallow_count;
    logic [PROG_W-1:0] prog_ratio;
    logic [31:0] seed;
    logic [13:0] exp_ref;
    logic exp_mod;
    logic [6:0] exp_sw;
    logic [10:0] exp_prog;
    int failures, check_count, cycles, since_strobe, scan_hits;
    logic both_q;

    pds_link_if link_if();

    pds_host #(.HALF_BIT_CYC(HALF)) pds_host_inst
    (
        .clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid), .cmd_word(cmd_word), .cmd_ready(cmd_ready),
        .cmd_error(cmd_error), .cmd_done(cmd_done), .link(link_if)
    );

    pds_device pds_device_inst
    (
        .clk_sys(clk_sys), .rst(rst), .link(link_if), .reference_osc_input(reference_osc_input),
        .vco_sense_input(vco_sense_input), .polarity_select_pin(polarity_select_pin),
        .pump_output(pump_output), .pump_output_oe(pump_output_oe), .scan_switch_output(scan_switch_output),
        .scan_switch_oe(scan_switch_oe), .pump_up_ext(pump_up_ext), .pump_down_ext(pump_down_ext),
        .compare_monitor_pin(compare_monitor_pin), .ref_ratio(ref_ratio),
        .prescale_modulus_bit(prescale_modulus_bit), .swallow_count(swallow_count), .prog_ratio(prog_ratio)
    );

    pds_link_props #(.H(HALF)) pds_link_props_inst
    (
        .clk_sys(clk_sys), .rst(rst), .serial_clock(link_if.serial_clock),
        .serial_data(link_if.serial_data), .load_strobe(link_if.load_strobe)
    );

    // Clock generation
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end

    // ----------
    // Helpers
    // ----------
    function automatic logic [31:0] xorshift(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction

    function automatic logic [31:0] ref_cycles(input logic [13:0] r);
        return r * 2 * OSC_HALF;
    endfunction

    function automatic logic [31:0] loop_cycles(input logic m, input logic [10:0] b, input logic [6:0] a);
        return ((m ? 32'h0000_0040 : 32'h0000_0080) * b + a) * 2 * VCO_HALF;
    endfunction

    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        check_count = check_count + 1;
        if (seen !== exp)
        begin
            failures = failures + 1;
            $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask

    // Hand one word to the host and wait for its answer
    task automatic send(input logic [WORD_W-1:0] w, output logic err);
        int n;
        n = 0;
        while (cmd_ready !== 1'b1 && n < 100)
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        cmd_word <= w;
        cmd_valid <= 1'b1;
        @(posedge clk_sys);
        cmd_valid <= 1'b0;
        n = 0;
        do
        begin
            @(posedge clk_sys);
            n = n + 1;
        end
        while (cmd_done !== 1'b1 && cmd_error !== 1'b1 && n < 400);
        err = cmd_error;
        repeat (6) @(posedge clk_sys);
    endtask

    task automatic check_latch();
        check(ref_ratio, exp_ref, "reference ratio");
        check(prescale_modulus_bit, exp_mod, "modulus bit");
        check(swallow_count, exp_sw, "swallow count");
        check(prog_ratio, exp_prog, "programmable ratio");
    endtask

    task automatic load_ref(input logic [13:0] r, input logic m);
        logic err;
        send({3'h0, m, r, 1'b1}, err);
        exp_ref = r;
        exp_mod = m;
        check(err, 0, "legal reference word refused");
        check_latch();
    endtask

    task automatic load_loop(input logic [10:0] b, input logic [6:0] a);
        logic err;
        send({b, a, 1'b0}, err);
        exp_prog = b;
        exp_sw = a;
        check(err, 0, "legal loop word refused");
        check_latch();
    endtask

    // Cycles between the second and third monitor pulses
    task automatic measure(output logic [31:0] gap);
        int n;
        gap = 32'h0;
        for (int k = 0; k < 3; k++)
        begin
            n = 0;
            do
            begin
                @(posedge clk_sys);
                n = n + 1;
            end
            while (compare_monitor_pin !== 1'b1 && n < 12000);
            gap = n;
        end
    endtask

    task automatic pump_bias(output logic up_more, output logic src_more);
        int up, dn, src, snk;
        up = 0;
        dn = 0;
        src = 0;
        snk = 0;
        repeat (2000)
        begin
            @(posedge clk_sys);
            up = up + (pump_up_ext === 1'b1);
            dn = dn + (pump_down_ext === 1'b1);
            src = src + (pump_output_oe === 1'b1 && pump_output === 1'b1);
            snk = snk + (pump_output_oe === 1'b1 && pump_output === 1'b0);
        end
        up_more = up > dn;
        src_more = src > snk;
    endtask

    // Oscillators, scan switch watch and timeout
    always @(posedge clk_sys)
    begin
        cycles <= cycles + 1;
        reference_osc_input <= ((cycles / OSC_HALF) % 2) == 1;
        vco_sense_input <= ((cycles / VCO_HALF) % 2) == 1;
        since_strobe <= (link_if.load_strobe === 1'b1) ? 0 : since_strobe + 1;
        if (scan_switch_oe === 1'b1 && since_strobe > 10)
            check(scan_switch_oe, 0, "scan switch outside strobe");
        if (scan_switch_oe === 1'b1)
            check({pump_output_oe, scan_switch_output}, {1'b1, pump_output}, "scan switch copy");
        scan_hits <= scan_hits + (scan_switch_oe === 1'b1);
        both_q <= pump_up_ext === 1'b1 && pump_down_ext === 1'b1;
        if (both_q === 1'b1 && pump_up_ext === 1'b1 && pump_down_ext === 1'b1)
            check(both_q, 0, "up and down held past minimum width");
        if (cycles == LIMIT)
        begin
            failures = failures + 1;
            conclude();
        end
    end

    // ----------
    // Main sequence
    // ----------
    initial
    begin
        logic err, up_more, src_more;
        logic [31:0] gap;
        logic [13:0] ratio;
        logic [10:0] prog;
        logic [6:0] sw;
        failures = 0;
        check_count = 0;
        cycles = 0;
        since_strobe = 0;
        scan_hits = 0;
        both_q = 1'b0;
        seed = 32'h76fe_525b;
        rst = 1'b1;
        cmd_valid = 1'b0;
        cmd_word = 19'h0_0000;
        reference_osc_input = 1'b0;
        vco_sense_input = 1'b0;
        polarity_select_pin = 1'b1;
        exp_ref = 14'h0003;
        exp_mod = 1'b0;
        exp_sw = 7'h00;
        exp_prog = 11'h003;
        repeat (4) @(posedge clk_sys);
        rst <= 1'b0;
        send(19'h0_0005, err);
        check(err, 1, "ratio two accepted");
        send(19'h0_0200, err);
        check(err, 1, "prog two accepted");
        send(19'h0_0308, err);
        check(err, 1, "swallow above prog accepted");
        check_latch();
        $display("test refused words done");
        load_ref(14'h0003, 1'b1);
        measure(gap);
        check(gap, ref_cycles(14'h0003), "reference period");
        seed = xorshift(seed);
        ratio = 14'h0003 + 14'(seed % 32);
        load_ref(ratio, 1'b1);
        measure(gap);
        check(gap, ref_cycles(ratio), "reference period");
        $display("test reference divider done");
        pump_bias(up_more, src_more);
        check(up_more, 1, "pump sense with fast reference");
        check(src_more, 1, "pump pin sense with fast reference");
        polarity_select_pin <= 1'b0;
        pump_bias(up_more, src_more);
        check(up_more, 0, "pump sense not inverted");
        check(src_more, 0, "pump pin sense not inverted");
        $display("test pump sense done");
        load_loop(11'h003, 7'h03);
        measure(gap);
        check(gap, loop_cycles(1'b1, 11'h003, 7'h03), "loop period");
        seed = xorshift(seed);
        prog = 11'h003 + 11'(seed % 4);
        sw = 7'((seed >> 8) % (prog + 1));
        load_ref(14'h0003, 1'b0);
        load_loop(prog, sw);
        measure(gap);
        check(gap, loop_cycles(1'b0, prog, sw), "loop period");
        $display("test loop divider done");
        load_ref(14'h3fff, 1'b1);
        load_loop(11'h7ff, 7'h7f);
        check(scan_hits > 0, 1, "scan switch never closed");
        $display("test boundary latches done");
        conclude();
    end

endmodule
